// file: rtl/pcc_cfg.svh
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH
// ****************************************************************
// Clock plan constants.
// ****************************************************************
`define PCC_XTAL_HZ 32768
`define PCC_PLL_MULT 125
`define PCC_PLL_HZ (`PCC_XTAL_HZ * `PCC_PLL_MULT)
`define PCC_SYS_HZ 20000000
`define PCC_NCO_W 25
`define PCC_METER_DIV 5
// ****************************************************************
// Register offsets.
// ****************************************************************
`define PCC_ADDR_KEY 8'hc1
`define PCC_ADDR_POW 8'hc5
`define PCC_ADDR_PCFG 8'hf4
`define PCC_ADDR_ADC_START 8'hd8
`define PCC_ADDR_INT_PIN 8'hff
`define PCC_ADDR_HUNDREDTHS 8'ha2
`define PCC_ADDR_SECONDS 8'ha3
`define PCC_ADDR_MINUTES 8'ha4
`define PCC_ADDR_HOURS 8'ha5
`define PCC_RTC_NUM 5
// ****************************************************************
// Keys, fields and reset values.
// ****************************************************************
`define PCC_KEY_POW 8'ha7
`define PCC_KEY_RTC 8'hea
`define PCC_KEY_RST 8'h00
`define PCC_POW_RST 8'h82
`define PCC_POW_WMASK 8'h77
`define PCC_POW_FIXED 8'h80
`define PCC_DIV_RST 3'h2
`define PCC_BIT_METERING_SHUTDOWN 6
`define PCC_BIT_CORE_OFF 4
`define PCC_BIT_FAULT 4
`define PCC_BIT_ACK 7
`endif

// file: rtl/pcc_pkg.sv
package pcc_pkg;
    // Register bus request as one carrier.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pcc_bus_req_t;

    // Which protected group the last key write opened.
    typedef enum logic [1:0] {
        PCC_ARM_NONE,
        PCC_ARM_POW,
        PCC_ARM_RTC
    } pcc_arm_t;

    // One-cycle clock enable pulses produced by the divider.
    typedef struct packed {
        logic pll_tick;
        logic core_tick;
        logic meter_tick;
    } pcc_clk_t;
endpackage : pcc_pkg

// file: rtl/pcc_clkdiv.sv
`include "pcc_cfg.svh"
module pcc_clkdiv import pcc_pkg::*; (
    input logic clk_sys,
    input logic srst,
    input logic run,
    input logic [2:0] div_sel,
    input logic core_gate,
    input logic meter_gate,
    output pcc_clk_t clk_out,
    output logic [2:0] div_active
);
    // ****************************************************************
    // Phase accumulator standing in for the locked PLL output.
    // ****************************************************************
    localparam logic [`PCC_NCO_W-1:0] NCO_INC = `PCC_NCO_W'(`PCC_PLL_HZ);
    localparam logic [`PCC_NCO_W-1:0] NCO_MOD = `PCC_NCO_W'(`PCC_SYS_HZ);
    logic [`PCC_NCO_W-1:0] acc_reg;
    logic [`PCC_NCO_W:0] acc_sum;
    logic pll_tick_reg;
    logic [6:0] core_cnt_reg;
    logic [2:0] meter_cnt_reg;
    logic core_tick_reg;
    logic meter_tick_reg;
    logic [6:0] core_last;

    assign acc_sum = {1'b0, acc_reg} + {1'b0, NCO_INC};
    assign core_last = 7'((8'h01 << div_active) - 8'h01);

    // The accumulator clears to zero while unlocked, so no divided clock runs.
    always_ff @(posedge clk_sys) begin
        if (srst || !run) begin
            acc_reg <= '0;
            pll_tick_reg <= 1'b0;
        end else if (acc_sum >= {1'b0, NCO_MOD}) begin
            acc_reg <= `PCC_NCO_W'(acc_sum - {1'b0, NCO_MOD});
            pll_tick_reg <= 1'b1;
        end else begin
            acc_reg <= acc_sum[`PCC_NCO_W-1:0];
            pll_tick_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Core divider, new ratio taken only at a period boundary.
    // ****************************************************************
    // Loading the ratio mid-period could cut a period short, hence the wait.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            core_cnt_reg <= '0;
            div_active <= `PCC_DIV_RST;
            core_tick_reg <= 1'b0;
        end else begin
            core_tick_reg <= 1'b0;
            if (pll_tick_reg) begin
                if (core_cnt_reg >= core_last) begin
                    core_cnt_reg <= '0;
                    div_active <= div_sel;
                    core_tick_reg <= core_gate;
                end else begin
                    core_cnt_reg <= core_cnt_reg + 7'h01;
                end
            end
        end
    end

    // Metering divider ignores the core ratio entirely.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meter_cnt_reg <= '0;
            meter_tick_reg <= 1'b0;
        end else begin
            meter_tick_reg <= 1'b0;
            if (pll_tick_reg) begin
                if (meter_cnt_reg == 3'(`PCC_METER_DIV - 1)) begin
                    meter_cnt_reg <= '0;
                    meter_tick_reg <= meter_gate;
                end else begin
                    meter_cnt_reg <= meter_cnt_reg + 3'h1;
                end
            end
        end
    end

    assign clk_out = '{pll_tick: pll_tick_reg, core_tick: core_tick_reg,
                       meter_tick: meter_tick_reg};
endmodule : pcc_clkdiv

// file: rtl/pcc_top.sv
`include "pcc_cfg.svh"
module pcc_top import pcc_pkg::*; (
    input logic clk_sys,
    input logic srst,
    input pcc_bus_req_t bus_req,
    output logic [7:0] rdata,
    input logic pll_locked,
    input logic battery_mode,
    output pcc_clk_t clk_out,
    output logic [2:0] core_clk_div_sel,
    output logic metering_shutdown,
    output logic core_shutdown,
    output logic core_rst
);
    // ****************************************************************
    // Declarations.
    // ****************************************************************
    logic [1:0] lock_sync_reg;
    logic [1:0] batt_sync_reg;
    logic lock_s;
    logic batt_s;
    logic lock_d_reg;
    logic was_locked_reg;
    logic lock_lost;
    logic [7:0] key_reg;
    pcc_arm_t arm_reg;
    pcc_arm_t arm_next;
    logic [7:0] pow_reg;
    logic fault_reg;
    logic core_rst_reg;
    logic [7:0] rtc_reg [`PCC_RTC_NUM];
    logic [7:0] rtc_addr [`PCC_RTC_NUM];
    logic [`PCC_RTC_NUM-1:0] rtc_hit;
    logic [7:0] rdata_reg;
    logic [7:0] rd_value;
    logic wr_key;
    logic wr_pow;
    logic wr_ack;
    logic pow_ok;
    logic rtc_ok;
    logic core_off;
    logic [2:0] div_run;

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    // Lock and battery levels come from other domains, so two stages each.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lock_sync_reg <= 2'h0;
            batt_sync_reg <= 2'h0;
        end else begin
            lock_sync_reg <= {lock_sync_reg[0], pll_locked};
            batt_sync_reg <= {batt_sync_reg[0], battery_mode};
        end
    end

    assign lock_s = lock_sync_reg[1];
    assign batt_s = batt_sync_reg[1];

    // ****************************************************************
    // Write decode.
    // ****************************************************************
    assign wr_key = bus_req.wr && (bus_req.addr == `PCC_ADDR_KEY);
    assign wr_pow = bus_req.wr && (bus_req.addr == `PCC_ADDR_POW);
    assign wr_ack = bus_req.wr && (bus_req.addr == `PCC_ADDR_ADC_START) &&
                    bus_req.wdata[`PCC_BIT_ACK];
    assign pow_ok = wr_pow && (arm_reg == PCC_ARM_POW);
    assign rtc_ok = (|rtc_hit) && (arm_reg == PCC_ARM_RTC);

    // ****************************************************************
    // Unlock key.
    // ****************************************************************
    // The key byte itself stays readable until software overwrites it.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            key_reg <= `PCC_KEY_RST;
        end else if (wr_key) begin
            key_reg <= bus_req.wdata;
        end
    end

    // Any write after the key disarms it, so one key opens one write only.
    always_comb begin
        arm_next = arm_reg;
        if (bus_req.wr) begin
            if (wr_key) begin
                case (bus_req.wdata)
                    `PCC_KEY_POW: arm_next = PCC_ARM_POW;
                    `PCC_KEY_RTC: arm_next = PCC_ARM_RTC;
                    default: arm_next = PCC_ARM_NONE;
                endcase
            end else begin
                arm_next = PCC_ARM_NONE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            arm_reg <= PCC_ARM_NONE;
        end else begin
            arm_reg <= arm_next;
        end
    end

    // ****************************************************************
    // Power and clock control register.
    // ****************************************************************
    // Bit 7 is held at one and bit 3 at zero whatever is written.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pow_reg <= `PCC_POW_RST;
        end else if (pow_ok) begin
            pow_reg <= (bus_req.wdata & `PCC_POW_WMASK) | `PCC_POW_FIXED;
        end
    end

    assign core_clk_div_sel = pow_reg[2:0];
    assign metering_shutdown = pow_reg[`PCC_BIT_METERING_SHUTDOWN];
    assign core_off = pow_reg[`PCC_BIT_CORE_OFF] && batt_s;
    assign core_shutdown = core_off;

    // ****************************************************************
    // Protected timekeeping and interrupt pin bytes.
    // ****************************************************************
    assign rtc_addr[0] = `PCC_ADDR_INT_PIN;
    assign rtc_addr[1] = `PCC_ADDR_HUNDREDTHS;
    assign rtc_addr[2] = `PCC_ADDR_SECONDS;
    assign rtc_addr[3] = `PCC_ADDR_MINUTES;
    assign rtc_addr[4] = `PCC_ADDR_HOURS;

    // Each byte only changes under an open time key.
    genvar gi;
    generate
        for (gi = 0; gi < `PCC_RTC_NUM; gi++) begin : g_rtc
            assign rtc_hit[gi] = bus_req.wr && (bus_req.addr == rtc_addr[gi]);
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    rtc_reg[gi] <= 8'h00;
                end else if (rtc_hit[gi] && (arm_reg == PCC_ARM_RTC)) begin
                    rtc_reg[gi] <= bus_req.wdata;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // PLL lock supervision.
    // ****************************************************************
    // Before the first lock nothing counts as a loss, so power-up is clean.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lock_d_reg <= 1'b0;
            was_locked_reg <= 1'b0;
        end else begin
            lock_d_reg <= lock_s;
            if (lock_s) begin
                was_locked_reg <= 1'b1;
            end
        end
    end

    assign lock_lost = was_locked_reg && !lock_s;

    // Setting wins over acknowledge, so the flag cannot clear while unlocked.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fault_reg <= 1'b0;
        end else if (lock_lost) begin
            fault_reg <= 1'b1;
        end else if (wr_ack) begin
            fault_reg <= 1'b0;
        end
    end

    // After the first lock, the core is held in reset for as long as lock is missing.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            core_rst_reg <= 1'b0;
        end else begin
            core_rst_reg <= lock_lost;
        end
    end

    assign core_rst = core_rst_reg;

    // ****************************************************************
    // Clock dividers.
    // ****************************************************************
    pcc_clkdiv u_clkdiv (
        .clk_sys(clk_sys),
        .srst(srst),
        .run(lock_s),
        .div_sel(pow_reg[2:0]),
        .core_gate(!core_off),
        .meter_gate(!pow_reg[`PCC_BIT_METERING_SHUTDOWN]),
        .clk_out(clk_out),
        .div_active(div_run)
    );

    // ****************************************************************
    // Read path.
    // ****************************************************************
    // The acknowledge bit is write-only, so the start register reads zero.
    always_comb begin
        rd_value = 8'h00;
        case (bus_req.addr)
            `PCC_ADDR_KEY: rd_value = key_reg;
            `PCC_ADDR_POW: rd_value = pow_reg;
            `PCC_ADDR_PCFG: rd_value[`PCC_BIT_FAULT] = fault_reg;
            `PCC_ADDR_INT_PIN: rd_value = rtc_reg[0];
            `PCC_ADDR_HUNDREDTHS: rd_value = rtc_reg[1];
            `PCC_ADDR_SECONDS: rd_value = rtc_reg[2];
            `PCC_ADDR_MINUTES: rd_value = rtc_reg[3];
            `PCC_ADDR_HOURS: rd_value = rtc_reg[4];
            default: rd_value = 8'h00;
        endcase
    end

    // Data stand only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= bus_req.rd ? rd_value : 8'h00;
        end
    end

    assign rdata = rdata_reg;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_pow_key_gate: assert property (
        (wr_pow && arm_reg != PCC_ARM_POW) |=> $stable(pow_reg))
        else $error("power control changed without key");

    a_pow_key_take: assert property (
        (wr_key && bus_req.wdata == `PCC_KEY_POW) ##1 wr_pow |=>
            pow_reg == ((($past(bus_req.wdata)) & `PCC_POW_WMASK) | `PCC_POW_FIXED))
        else $error("keyed power control write lost");

    a_rtc_key_gate: assert property (
        (rtc_hit[2] && arm_reg != PCC_ARM_RTC) |=> $stable(rtc_reg[2]))
        else $error("seconds byte changed without key");

    a_key_one_shot: assert property (
        (bus_req.wr && !wr_key) |=> arm_reg == PCC_ARM_NONE)
        else $error("key stayed open after a write");

    a_div_reset_val: assert property (
        $past(srst) |-> core_clk_div_sel == `PCC_DIV_RST)
        else $error("divider reset value wrong");

    a_fault_on_loss: assert property (
        (was_locked_reg && lock_d_reg && !lock_s) |=> fault_reg && core_rst)
        else $error("lock loss not flagged");

    a_fault_held: assert property (
        lock_lost |=> fault_reg)
        else $error("fault flag low while unlocked");

    a_ack_clears: assert property (
        (wr_ack && !lock_lost) |=> !fault_reg)
        else $error("acknowledge did not clear fault");

    a_meter_spacing: assert property (
        clk_out.meter_tick |=> !clk_out.meter_tick [*8])
        else $error("metering clock too fast");

    a_metering_shutdown: assert property (
        metering_shutdown [*3] |-> !clk_out.meter_tick)
        else $error("metering ran while shut down");

    a_core_off: assert property (
        core_off [*3] |-> !clk_out.core_tick)
        else $error("core clock ran while shut down");

    a_core_spacing: assert property (
        clk_out.core_tick |=> !clk_out.core_tick [*3])
        else $error("core clock runt pulse");

    // These checks look one edge after the cause, where registered state has settled.
    // A new ratio may only be taken at the edge that closes a full core period.
    a_div_switch: assert property (
        ($changed(div_run) && !$past(core_off)) |-> clk_out.core_tick)
        else $error("divider ratio changed inside a core period");

    a_pll_halt: assert property (
        !lock_s |=> !clk_out.pll_tick)
        else $error("pll tick while unlocked");

    a_core_rst_clear: assert property (
        lock_s |=> !core_rst)
        else $error("core reset held while locked");

    a_ack_set_wins: assert property (
        (wr_ack && lock_lost) |=> fault_reg)
        else $error("acknowledge cleared fault while unlocked");

    a_fault_read: assert property (
        (bus_req.rd && bus_req.addr == `PCC_ADDR_PCFG) |=>
            rdata[`PCC_BIT_FAULT] == $past(fault_reg))
        else $error("fault flag read back wrong");

    a_rtc_key_take: assert property (
        (rtc_hit[0] && arm_reg == PCC_ARM_RTC) |=> rtc_reg[0] == $past(bus_req.wdata))
        else $error("keyed interrupt pin write lost");

    a_key_other: assert property (
        (wr_key && bus_req.wdata != `PCC_KEY_POW && bus_req.wdata != `PCC_KEY_RTC) |=>
            arm_reg == PCC_ARM_NONE)
        else $error("unknown key value left a group open");

    a_pow_fixed_bits: assert property (
        (pow_reg & ~`PCC_POW_WMASK) == `PCC_POW_FIXED)
        else $error("power control fixed bits wrong");

    // ****************************************************************
    // Cover points.
    // ****************************************************************
    // Keyed writes, fault entry and exit, and a live ratio change.
    c_pow_write: cover property (pow_ok);
    c_rtc_write: cover property (rtc_ok);
    c_fault_set: cover property ($rose(fault_reg));
    c_fault_ack: cover property ($fell(fault_reg));
    c_div_change: cover property ($changed(div_run));
endmodule : pcc_top

// file: sim/tb_pll_core_clock_control.sv
`include "pcc_cfg.svh"
// Compares two values, counts the comparison and reports a difference at once.
`define check_eq(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_pll_core_clock_control import pcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys;
    logic srst;
    pcc_bus_req_t bus_req;
    logic [7:0] rdata;
    logic pll_locked;
    logic battery_mode;
    pcc_clk_t clk_out;
    logic [2:0] core_clk_div_sel;
    logic metering_shutdown;
    logic core_shutdown;
    logic core_rst;
    logic rd_d;
    logic [7:0] exp_q[$];
    logic [7:0] exp_rd;
    int n_mismatch = 0;
    int checks_done = 0;

    pcc_top DUT (
        .clk_sys(clk_sys),
        .srst(srst),
        .bus_req(bus_req),
        .rdata(rdata),
        .pll_locked(pll_locked),
        .battery_mode(battery_mode),
        .clk_out(clk_out),
        .core_clk_div_sel(core_clk_div_sel),
        .metering_shutdown(metering_shutdown),
        .core_shutdown(core_shutdown),
        .core_rst(core_rst)
    );

    // ****************************************************************
    // Clock and closing report.
    // ****************************************************************
    // A 50 ns period gives the 20 MHz system clock.
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // ****************************************************************
    // Bus master tasks.
    // ****************************************************************
    // One write cycle; the strobe stays up if another request follows.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask : wr

    // One read cycle; the expected byte is queued for the watcher.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
    endtask : rd

    task automatic idle(input int n);
        @(posedge clk_sys);
        bus_req <= '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        repeat (n) @(posedge clk_sys);
    endtask : idle

    // ****************************************************************
    // Output watcher.
    // ****************************************************************
    // Read data is registered, so it is judged at the falling edge after the strobe.
    always @(posedge clk_sys) begin
        rd_d <= bus_req.rd;
    end

    always @(negedge clk_sys) begin
        if (!srst && rd_d === 1'b1 && exp_q.size() == 0) begin
            n_mismatch++;
            $display("mismatch at %0t: read data with nothing expected", $time);
        end else if (!srst && rd_d === 1'b1) begin
            // The note is taken off once, so a mismatch report shows the same value.
            exp_rd = exp_q.pop_front();
            `check_eq(rdata, exp_rd)
        end else if (!srst) begin
            `check_eq(rdata, 8'h00)
        end
    end

    function automatic logic pick(input int sel);
        return (sel == 1) ? clk_out.core_tick : clk_out.meter_tick;
    endfunction : pick

    // Counts PLL ticks from one selected tick to the next, with a bound.
    task automatic gap(input int sel, output int n);
        int t;
        n = 0;
        t = 0;
        do begin
            @(negedge clk_sys);
            t++;
        end while (pick(sel) !== 1'b1 && t < 5000);
        do begin
            @(negedge clk_sys);
            t++;
            if (clk_out.pll_tick === 1'b1) n++;
        end while (pick(sel) !== 1'b1 && t < 5000);
        if (t >= 5000) begin
            n_mismatch++;
            $display("mismatch at %0t: tick never came", $time);
            stop_test();
        end
    endtask : gap

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        int n;
        int k;
        logic [7:0] v;
        logic [7:0] tk[5];
        tk = '{8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'hff};
        srst = 1'b1;
        bus_req = '0;
        pll_locked = 1'b1;
        battery_mode = 1'b0;
        void'($urandom(27383));
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        // Reset values of registers and outputs.
        `check_eq(core_clk_div_sel, 3'h2)
        `check_eq(metering_shutdown, 1'b0)
        rd(8'hc5, 8'h82);
        rd(8'hc1, 8'h00);
        rd(8'hf4, 8'h00);
        rd(8'hd8, 8'h00);
        // A write without the key, and a key spent or broken, are ignored.
        wr(8'hc5, 8'h07);
        wr(8'hc1, 8'ha7);
        wr(8'h10, 8'h55);
        wr(8'hc5, 8'h07);
        rd(8'hc5, 8'h82);
        wr(8'hc1, 8'hea);
        wr(8'hc5, 8'h07);
        rd(8'hc5, 8'h82);
        wr(8'hc1, 8'ha7);
        rd(8'hc1, 8'ha7);
        wr(8'hc5, 8'h03);
        wr(8'hc5, 8'h05);
        rd(8'hc5, 8'h83);
        idle(2);
        // Every divider code, with the metering switched off on odd codes.
        for (k = 0; k < 8; k++) begin
            v = (8'($urandom) & 8'h88) | 8'(k) | ((k % 2) ? 8'h40 : 8'h00);
            wr(8'hc1, 8'ha7);
            wr(8'hc5, v);
            rd(8'hc5, (v & 8'h77) | 8'h80);
            idle(2);
            `check_eq(core_clk_div_sel, 3'(k))
            `check_eq(metering_shutdown, v[6])
            gap(1, n);
            gap(1, n);
            gap(1, n);
            `check_eq(n, 1 << k)
            if (k % 2 == 0) begin
                gap(2, n);
                gap(2, n);
                `check_eq(n, 5)
            end else begin
                n = 0;
                repeat (60) @(negedge clk_sys) n += int'(clk_out.meter_tick === 1'b1);
                `check_eq(n, 0)
            end
        end
        // Core shutdown needs battery mode as well as the control bit.
        wr(8'hc1, 8'ha7);
        wr(8'hc5, 8'h12);
        idle(4);
        `check_eq(core_shutdown, 1'b0)
        battery_mode <= 1'b1;
        idle(4);
        `check_eq(core_shutdown, 1'b1)
        n = 0;
        repeat (60) @(negedge clk_sys) n += int'(clk_out.core_tick === 1'b1);
        `check_eq(n, 0)
        battery_mode <= 1'b0;
        idle(4);
        `check_eq(core_shutdown, 1'b0)
        // The time group opens only with its own key, one write each.
        foreach (tk[i]) begin
            v = 8'($urandom);
            wr(8'hc1, 8'hea);
            wr(tk[i], v);
            wr(tk[i], ~v);
            wr(8'hc1, 8'ha7);
            wr(tk[i], 8'h00);
            wr(8'hc1, 8'h00);
            rd(tk[i], v);
        end
        idle(2);
        // Lock loss resets the core and raises the fault until acknowledged.
        pll_locked <= 1'b0;
        idle(4);
        `check_eq(core_rst, 1'b1)
        n = 0;
        repeat (20) @(negedge clk_sys) n += int'(clk_out.pll_tick === 1'b1);
        `check_eq(n, 0)
        rd(8'hf4, 8'h10);
        wr(8'hd8, 8'h80);
        rd(8'hf4, 8'h10);
        pll_locked <= 1'b1;
        idle(5);
        `check_eq(core_rst, 1'b0)
        rd(8'hf4, 8'h10);
        wr(8'hd8, 8'h7f);
        rd(8'hf4, 8'h10);
        wr(8'hd8, 8'h80);
        rd(8'hf4, 8'h00);
        idle(4);
        // The locked accumulator repeats every 625 cycles, with 128 ticks in each turn.
        n = 0;
        repeat (625) @(negedge clk_sys) n += int'(clk_out.pll_tick === 1'b1);
        `check_eq(n, 128)
        gap(1, n);
        gap(1, n);
        gap(1, n);
        `check_eq(n, 4)
        stop_test();
    end
endmodule : tb_pll_core_clock_control
